/* verilog/sdc_pkg.sv */
// Constants, field layouts and carrier types of the stepper drive control
// Function
// RULE_01 - Command word is the last 20 bits shifted before chip select rises.
// RULE_02 - Words with bits 19 and 18 both zero load the driver control register.
// RULE_03 - Controller writes zero into all reserved driver control positions.
// RULE_04 - Response layout follows the response select field of driver configuration.
// RULE_05 - Select zero returns the microstep position in response bits 19 to 10.
// RULE_06 - Select zero returns eight status flags in bits 7 down to 0.
// RULE_07 - Select one returns the full load measurement in bits 19 to 10.
// RULE_08 - Select two returns upper load bits and current scale in 19 to 10.
// RULE_09 - Response bits 9 and 8 are always zero.
// RULE_10 - Step input disable bit picks one of two driver control layouts.
// RULE_11 - Disable set: step inputs ignored, coil currents taken from control word.
// RULE_12 - Disable clear: step and direction act, control word configures them.
// RULE_13 - Direct mode bit 17 is the coil A current sign.
// RULE_14 - Direct mode bits 16 to 9 are the coil A magnitude.
// RULE_15 - Direct mode bit 8 is the coil B current sign.
// RULE_16 - Direct mode bits 7 to 0 are the coil B magnitude.
// RULE_17 - With full hysteresis or offset, controller keeps magnitudes within 0 to 248.
// RULE_18 - Step mode bit 9 enables splitting each step into 16 microsteps; resolution codes 0 to 3 split into only 1, 2, 4 or 8.
// RULE_19 - Step mode bit 8 makes both step edges active, else rising only.
// RULE_20 - Step mode bits 3 to 0 set microsteps per quarter, 256 down to full.
package sdc_pkg;
    localparam int WORD_BITS = 20;
    localparam logic [1:0] CTRL_ADDR = 2'h0;
    localparam logic [2:0] CONF_ADDR = 3'h7;
    localparam int CONF_DISABLE_BIT = 7;
    localparam int CONF_SELECT_LSB = 4;
    localparam int COIL_A_SIGN_BIT = 17;
    localparam int COIL_A_MAG_LSB = 9;
    localparam int COIL_B_SIGN_BIT = 8;
    localparam int COIL_B_MAG_LSB = 0;
    localparam int INTERP_BIT = 9;
    localparam int DOUBLE_EDGE_BIT = 8;
    localparam int RESOLUTION_LSB = 0;
    localparam int GAP_BIT_LSB = 8;
    localparam logic [1:0] SELECT_POSITION = 2'h0;
    localparam logic [1:0] SELECT_LOAD = 2'h1;
    localparam logic [1:0] SELECT_SCALE = 2'h2;
    localparam logic [3:0] RESOLUTION_FULL = 4'h8;
    localparam logic [3:0] RESOLUTION_SPLIT_MIN = 4'h4;
    localparam logic [4:0] INTERP_SUBSTEPS = 5'h10;
    localparam logic [19:0] CTRL_RESET = 20'h00000;
    localparam logic DISABLE_RESET = 1'b0;
    localparam logic [1:0] SELECT_RESET = 2'h0;
    localparam logic [9:0] POSITION_RESET = 10'h000;
    localparam logic [19:0] RESPONSE_RESET = 20'h00000;
    localparam int CLOCK_NS = 100;
    localparam int INTERP_GAP_NS = 400;
    localparam int INTERP_GAP_CYCLES = (INTERP_GAP_NS + CLOCK_NS - 1) / CLOCK_NS;

    typedef struct packed {
        logic standstill_flag;
        logic open_load_b;
        logic open_load_a;
        logic short_ground_b;
        logic short_ground_a;
        logic overtemp_warning;
        logic overtemp_shutdown;
        logic load_detect_flag;
    } sdc_flags_type;

    typedef struct packed {
        sdc_flags_type flags;
        logic [9:0] load_measurement;
        logic [4:0] adaptive_current_scale;
    } sdc_status_type;

    typedef struct packed {
        logic coil_a_sign;
        logic [7:0] coil_a_magnitude;
        logic coil_b_sign;
        logic [7:0] coil_b_magnitude;
    } sdc_coil_type;

    typedef struct packed {
        logic step_interpolation;
        logic double_edge_step;
        logic [3:0] microstep_resolution;
    } sdc_stepcfg_type;

    typedef struct packed {
        logic sck_meta;
        logic sck_s;
        logic sck_d;
        logic sdi_meta;
        logic sdi_s;
        logic cs_meta;
        logic cs_s;
        logic cs_d;
        logic sample;
        logic [19:0] shifter;
        logic sdo;
        logic word_valid;
        logic [19:0] word;
    } sdc_spi_state_type;

    typedef struct packed {
        logic [19:0] ctrl;
        logic step_input_disable;
        logic [1:0] response_select;
        logic step_meta;
        logic step_s;
        logic step_d;
        logic dir_meta;
        logic dir_s;
        logic [9:0] position;
        logic [4:0] sub_left;
        logic [9:0] sub_size;
        logic sub_dir;
        logic [7:0] gap;
    } sdc_state_type;
endpackage

/* verilog/sdc_spi_shift.sv */
// Serial shift engine: pin sync, 20-bit command capture, response shift
`timescale 1ns/1ps
`default_nettype none
module sdc_spi_shift import sdc_pkg::*; (
    input wire logic clock,
    input wire logic rst,
    input wire logic sck,
    input wire logic sdi,
    input wire logic chip_select_n,
    input wire logic [19:0] response,
    output logic sdo,
    output logic sdo_oe,
    output logic word_valid,
    output logic [19:0] word
);
    sdc_spi_state_type s_reg, s_next;
    logic sck_rise, sck_fall, cs_fall, cs_rise;

    always_comb begin
        sck_rise = s_reg.sck_s && !s_reg.sck_d;
        sck_fall = !s_reg.sck_s && s_reg.sck_d;
        cs_fall = !s_reg.cs_s && s_reg.cs_d;
        cs_rise = s_reg.cs_s && !s_reg.cs_d;
        s_next = s_reg;
        s_next.sck_meta = sck;
        s_next.sck_s = s_reg.sck_meta;
        s_next.sck_d = s_reg.sck_s;
        s_next.sdi_meta = sdi;
        s_next.sdi_s = s_reg.sdi_meta;
        s_next.cs_meta = chip_select_n;
        s_next.cs_s = s_reg.cs_meta;
        s_next.cs_d = s_reg.cs_s;
        s_next.word_valid = 1'b0;
        if (cs_fall) begin
            s_next.shifter = response;
            s_next.sdo = response[WORD_BITS-1];
        end else if (!s_reg.cs_s) begin
            if (sck_rise) begin
                s_next.sample = s_reg.sdi_s;
            end
            // Old bits fall out the top, so longer frames chain through
            if (sck_fall) begin
                s_next.shifter = {s_reg.shifter[18:0], s_reg.sample};
                s_next.sdo = s_reg.shifter[18];
            end
        end
        if (cs_rise) begin
            s_next.word_valid = 1'b1;
            // Last sck fall has already moved the final bit in
            s_next.word = s_reg.shifter; // [RULE_01]
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_reg <= '{sck_meta: 1'b0, sck_s: 1'b0, sck_d: 1'b0,
                sdi_meta: 1'b0, sdi_s: 1'b0, cs_meta: 1'b1, cs_s: 1'b1,
                cs_d: 1'b1, sample: 1'b0, shifter: RESPONSE_RESET,
                sdo: 1'b0, word_valid: 1'b0, word: RESPONSE_RESET};
        end else begin
            s_reg <= s_next;
        end
    end

    assign sdo = s_reg.sdo;
    assign sdo_oe = !s_reg.cs_d;
    assign word_valid = s_reg.word_valid;
    assign word = s_reg.word;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_word_after_rise: assert property ( // [RULE_01]
        word_valid |-> s_reg.cs_d && !$past(s_reg.cs_d))
        else $error("command word not tied to chip select rise");
    a_word_last_bit: assert property ( // [RULE_01]
        cs_rise |=> word[0] == $past(s_reg.sample))
        else $error("command word misses the last bit shifted");
endmodule
`default_nettype wire

/* verilog/sdc_top.sv */
// Driver control decode, step handling and serial response assembly
`timescale 1ns/1ps
`default_nettype none
module sdc_top import sdc_pkg::*; #(
    parameter logic [7:0] GAP_CYCLES = 8'(INTERP_GAP_CYCLES)
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic sck,
    input wire logic sdi,
    input wire logic chip_select_n,
    output logic sdo,
    output logic sdo_oe,
    input wire logic step_in,
    input wire logic dir_in,
    input wire sdc_status_type status,
    output logic direct_mode,
    output sdc_coil_type coil,
    output sdc_stepcfg_type step_cfg,
    output logic [9:0] microstep_position
);
    sdc_state_type s_reg, s_next;
    logic word_valid;
    logic [19:0] word;
    logic [19:0] response;
    logic [3:0] res_eff;
    logic [9:0] units;
    logic [9:0] flush;
    logic [9:0] base;
    logic step_edge;
    logic busy;

    sdc_spi_shift u_shift (
        .clock(clock),
        .rst(rst),
        .sck(sck),
        .sdi(sdi),
        .chip_select_n(chip_select_n),
        .response(response),
        .sdo(sdo),
        .sdo_oe(sdo_oe),
        .word_valid(word_valid),
        .word(word)
    );

    always_comb begin
        response[9:8] = 2'h0; // [RULE_09]
        response[7:0] = status.flags; // [RULE_06]
        case (s_reg.response_select) // [RULE_04]
            SELECT_LOAD: begin
                response[19:10] = status.load_measurement; // [RULE_07]
            end
            SELECT_SCALE: begin
                response[19:10] = {status.load_measurement[9:5],
                    status.adaptive_current_scale}; // [RULE_08]
            end
            default: begin
                response[19:10] = s_reg.position; // [RULE_05]
            end
        endcase
    end

    always_comb begin
        // Codes above full step have no meaning; treat them as full step
        res_eff = (step_cfg.microstep_resolution > RESOLUTION_FULL) ?
            RESOLUTION_FULL : step_cfg.microstep_resolution;
        units = 10'h001 << res_eff; // [RULE_20]
        busy = s_reg.sub_left != 5'h00;
        // A step that lands mid-split completes the old step at once
        flush = 10'(s_reg.sub_left * s_reg.sub_size);
        base = s_reg.sub_dir ? s_reg.position + flush :
            s_reg.position - flush;
        step_edge = (s_reg.step_s != s_reg.step_d) &&
            (s_reg.step_s || step_cfg.double_edge_step); // [RULE_19]
        s_next = s_reg;
        s_next.step_meta = step_in;
        s_next.step_s = s_reg.step_meta;
        s_next.step_d = s_reg.step_s;
        s_next.dir_meta = dir_in;
        s_next.dir_s = s_reg.dir_meta;
        if (s_reg.step_input_disable) begin
            s_next.sub_left = 5'h00; // [RULE_11]
        end else if (step_edge) begin // [RULE_12]
            s_next.sub_dir = s_reg.dir_s;
            if (step_cfg.step_interpolation) begin // [RULE_18]
                s_next.position = base;
                s_next.gap = 8'h00;
                if (res_eff >= RESOLUTION_SPLIT_MIN) begin
                    s_next.sub_left = INTERP_SUBSTEPS;
                    s_next.sub_size = units >> 4;
                end else begin
                    s_next.sub_left = units[4:0];
                    s_next.sub_size = 10'h001;
                end
            end else begin
                s_next.sub_left = 5'h00;
                s_next.position = s_reg.dir_s ? base + units :
                    base - units; // [RULE_20]
            end
        end else if (busy) begin
            if (s_reg.gap == 8'h00) begin
                s_next.position = s_reg.sub_dir ?
                    s_reg.position + s_reg.sub_size :
                    s_reg.position - s_reg.sub_size; // [RULE_18]
                s_next.sub_left = s_reg.sub_left - 5'h01;
                s_next.gap = GAP_CYCLES - 8'h01;
            end else begin
                s_next.gap = s_reg.gap - 8'h01;
            end
        end
        if (word_valid) begin
            if (word[19:18] == CTRL_ADDR) begin
                s_next.ctrl = word; // [RULE_02]
            end else if (word[19:17] == CONF_ADDR) begin
                s_next.step_input_disable = word[CONF_DISABLE_BIT]; // [RULE_10]
                s_next.response_select =
                    word[CONF_SELECT_LSB +: 2]; // [RULE_04]
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_reg <= '{ctrl: CTRL_RESET, step_input_disable: DISABLE_RESET,
                response_select: SELECT_RESET, step_meta: 1'b0,
                step_s: 1'b0, step_d: 1'b0, dir_meta: 1'b0, dir_s: 1'b0,
                position: POSITION_RESET, sub_left: 5'h00,
                sub_size: 10'h000, sub_dir: 1'b0, gap: 8'h00};
        end else begin
            s_reg <= s_next;
        end
    end

    // Control word fields; which layout applies follows direct_mode
    assign direct_mode = s_reg.step_input_disable; // [RULE_10]
    assign coil.coil_a_sign = s_reg.ctrl[COIL_A_SIGN_BIT]; // [RULE_13]
    assign coil.coil_a_magnitude = s_reg.ctrl[COIL_A_MAG_LSB +: 8]; // [RULE_14]
    assign coil.coil_b_sign = s_reg.ctrl[COIL_B_SIGN_BIT]; // [RULE_15]
    assign coil.coil_b_magnitude = s_reg.ctrl[COIL_B_MAG_LSB +: 8]; // [RULE_16]
    assign step_cfg.step_interpolation = s_reg.ctrl[INTERP_BIT]; // [RULE_18]
    assign step_cfg.double_edge_step = s_reg.ctrl[DOUBLE_EDGE_BIT]; // [RULE_19]
    assign step_cfg.microstep_resolution =
        s_reg.ctrl[RESOLUTION_LSB +: 4]; // [RULE_20]
    assign microstep_position = s_reg.position;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_ctrl_capture: assert property ( // [RULE_02]
        word_valid && word[19:18] == 2'h0 |=> s_reg.ctrl == $past(word))
        else $error("control word not loaded");
    a_ctrl_other_kept: assert property ( // [RULE_02]
        word_valid && word[19:18] != 2'h0 |=> $stable(s_reg.ctrl))
        else $error("control register changed by another address");
    a_disable_capture: assert property ( // [RULE_10]
        word_valid && word[19:17] == 3'h7 |=>
        direct_mode == $past(word[7]) &&
        s_reg.response_select == $past(word[5:4]))
        else $error("configuration fields not loaded");
    a_direct_frozen: assert property ( // [RULE_11]
        direct_mode |=> $stable(microstep_position))
        else $error("position moved in direct mode");
    a_resp_gap_zero: assert property ( // [RULE_09]
        response[9:8] == 2'h0)
        else $error("response bits 9 and 8 not zero");
    a_resp_position: assert property ( // [RULE_05]
        s_reg.response_select == 2'h0 |->
        response[19:10] == microstep_position &&
        response[7:0] == status.flags) // [RULE_06]
        else $error("position response layout wrong");
    a_resp_load: assert property ( // [RULE_07]
        s_reg.response_select == 2'h1 |->
        response[19:10] == status.load_measurement)
        else $error("load response layout wrong");
    a_resp_scale: assert property ( // [RULE_08]
        s_reg.response_select == 2'h2 |->
        response[19:15] == status.load_measurement[9:5] &&
        response[14:10] == status.adaptive_current_scale)
        else $error("scale response layout wrong");
    a_full_step_move: assert property ( // [RULE_20]
        !direct_mode && step_edge && !busy && s_reg.dir_s &&
        !step_cfg.step_interpolation && step_cfg.microstep_resolution == 4'h8
        |=> microstep_position == $past(microstep_position) + 10'h100)
        else $error("full step did not move 256 positions");
    a_fall_ignored: assert property ( // [RULE_19]
        !direct_mode && !busy && !step_cfg.double_edge_step &&
        !s_reg.step_s && s_reg.step_d |=> $stable(microstep_position))
        else $error("falling step edge acted in single edge mode");
    a_split_sixteen: assert property ( // [RULE_18]
        !direct_mode && step_edge && step_cfg.step_interpolation &&
        step_cfg.microstep_resolution == 4'h4 |=>
        s_reg.sub_left == 5'h10 ##1 s_reg.sub_left == 5'h0f)
        else $error("interpolation did not split into 16");

    c_direct_write: cover property (
        word_valid && word[19:18] == 2'h0 && direct_mode);
    c_interp_run: cover property (busy && s_reg.sub_left == 5'h01);
    c_scale_select: cover property (s_reg.response_select == 2'h2);
    c_mid_split: cover property (!direct_mode && step_edge && busy);
endmodule
`default_nettype wire

/* bench/sdc_spi_master.sv */
// Serial master model for the control link, mode 0, MSB first
`timescale 1ns/1ps
`default_nettype none
module sdc_spi_master (
    input wire logic clock,
    input wire logic sdo,
    output logic sck,
    output logic sdi,
    output logic chip_select_n
);
    // Link clock idles low between frames
    initial begin
        sck = 1'b0;
        sdi = 1'b0;
        chip_select_n = 1'b1;
    end

    task automatic gap(input int n);
        repeat (n) @(negedge clock);
    endtask

    // 400 ns per half period; only the first 20 bits read are response
    task automatic xfer(input logic [31:0] w, input int n,
                        output logic [19:0] r);
        int i;
        r = 20'h00000;
        chip_select_n = 1'b0;
        gap(4);
        for (i = n - 1; i >= 0; i--) begin
            sdi = w[i];
            gap(4);
            sck = 1'b1;
            if (i >= n - 20)
                r = {r[18:0], sdo};
            gap(4);
            sck = 1'b0;
        end
        gap(4);
        chip_select_n = 1'b1;
        // Released data line must not keep looking valid
        sdi = ~sdi;
        gap(6);
    endtask
endmodule
`default_nettype wire

/* bench/stepper_drive_control_readback_bench.sv */
// Self-checking bench for the drive control decode and serial response
`timescale 1ns/1ps
`default_nettype none
module stepper_drive_control_readback_bench import sdc_pkg::*;;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic step_in = 1'b0;
    logic dir_in = 1'b1;
    sdc_status_type status = '0;
    logic sck, sdi, chip_select_n, sdo, sdo_oe, direct_mode;
    sdc_coil_type coil;
    sdc_stepcfg_type step_cfg;
    logic [9:0] microstep_position;
    int fails = 0;
    int comparisons = 0;
    logic [19:0] r;
    logic [9:0] pos = 10'h000;
    logic oe_seen = 1'b0;

    always #50 clock = ~clock;

    // Output enable as the master sees it while clocking a frame
    always @(posedge sck) oe_seen = sdo_oe;

    sdc_top #(.GAP_CYCLES(8'h01)) u_sdc_top (.clock(clock), .rst(rst),
        .sck(sck), .sdi(sdi), .chip_select_n(chip_select_n), .sdo(sdo),
        .sdo_oe(sdo_oe), .step_in(step_in), .dir_in(dir_in),
        .status(status), .direct_mode(direct_mode), .coil(coil),
        .step_cfg(step_cfg), .microstep_position(microstep_position));

    sdc_spi_master u_sdc_spi_master (.clock(clock), .sdo(sdo), .sck(sck),
        .sdi(sdi), .chip_select_n(chip_select_n));

    task automatic check(input string what, input logic [19:0] exp,
                         input logic [19:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wr(input logic [19:0] w);
        u_sdc_spi_master.xfer({12'h000, w}, 20, r);
    endtask

    // Configuration word with all other positions left zero
    function automatic logic [19:0] conf(input logic dis,
                                         input logic [1:0] sel);
        return {3'b111, 9'h000, dis, 1'b0, sel, 4'h0};
    endfunction

    task automatic pulse(input int hold);
        step_in = 1'b1;
        repeat (hold) @(negedge clock);
        step_in = 1'b0;
        repeat (hold) @(negedge clock);
    endtask

    task automatic check_pos(input string what);
        check(what, {10'h000, pos}, {10'h000, microstep_position});
    endtask

    initial begin
        int k;
        logic [19:0] e;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        repeat (3) @(negedge clock);
        check_pos("position at reset");
        check("mode at reset", 20'h00000, {19'h0, direct_mode});
        check("oe idle", 20'h00000, {19'h0, sdo_oe});
        $display("test reset done");
        // Rising edges only; falling edge of each pulse must not move
        for (k = 0; k < 9; k++) begin
            wr(20'(k));
            check("step config", 20'(k), {14'h0, step_cfg});
            pulse(8);
            pos = pos + 10'(1 << k);
            check_pos("resolution step");
        end
        check("oe in frame", 20'h00001, {19'h0, oe_seen});
        check("oe after frame", 20'h00000, {19'h0, sdo_oe});
        $display("test resolution done");
        wr(20'h00108);
        dir_in = 1'b0;
        step_in = 1'b1;
        repeat (8) @(negedge clock);
        pos = pos - 10'h100;
        check_pos("double edge rise");
        step_in = 1'b0;
        repeat (8) @(negedge clock);
        pos = pos - 10'h100;
        check_pos("double edge fall");
        $display("test double edge done");
        wr(20'h00204);
        check("interp config", 20'h00024, {14'h0, step_cfg});
        dir_in = 1'b1;
        pulse(8);
        repeat (24) @(negedge clock);
        pos = pos + 10'h010;
        check_pos("interpolated step");
        // Codes above full step act as full step
        wr(20'h0020f);
        pulse(8);
        repeat (24) @(negedge clock);
        pos = pos + 10'h100;
        check_pos("interpolated full step");
        wr(20'h00202);
        pulse(8);
        repeat (24) @(negedge clock);
        pos = pos + 10'h004;
        check_pos("interpolated coarse");
        // Second edge lands mid-split; nothing may be lost
        wr(20'h00204);
        pulse(2);
        pulse(2);
        repeat (40) @(negedge clock);
        pos = pos + 10'h020;
        check_pos("interpolation restart");
        $display("test interpolation done");
        status = {8'ha5, 10'h2b6, 5'h13};
        for (k = 0; k < 4; k++) begin
            wr(conf(1'b0, 2'(k)));
            u_sdc_spi_master.xfer({12'h000, conf(1'b0, 2'(k))}, 20, r);
            e = {pos, 2'b00, 8'ha5};
            if (k == 1)
                e = {10'h2b6, 2'b00, 8'ha5};
            else if (k == 2)
                e = {5'h15, 5'h13, 2'b00, 8'ha5};
            check("response", e, r);
            check("response", e, r);
        end
        $display("test response done");
        wr(conf(1'b1, 2'h0));
        check("direct mode", 20'h00001, {19'h0, direct_mode});
        // Magnitudes kept at or below 248
        u_sdc_spi_master.xfer({12'hfff, 20'h3f007}, 32, r);
        check("coil word", 20'h3f007, {2'h0, coil});
        check("coil a", 20'h3f007, {2'h0, coil});
        wr(20'h001f8);
        check("coil b", 20'h001f8, {2'h0, coil});
        wr(20'h8ffff);
        wr(20'h4ffff);
        check("refused word", 20'h001f8, {2'h0, coil});
        pulse(8);
        repeat (24) @(negedge clock);
        check_pos("step in direct mode");
        $display("test direct mode done");
        give_verdict();
    end

    initial begin
        #3_000_000;
        fails++;
        give_verdict();
    end
endmodule
`default_nettype wire
